// >>> core/cijop_pkg.sv
// cijop_pkg: opcodes, field widths and the branch delay of the compare/jump unit
// assumes the issuing pipeline presents already-decoded operands
package cijop_pkg;
  localparam int CIJOP_W = 32;
  localparam int CIJOP_IMM7_W = 7;
  localparam int CIJOP_OPC_W = 8;
  localparam logic [7:0] CIJOP_OPC_GTR = 8'h0F;
  localparam logic [7:0] CIJOP_OPC_GTRI = 8'h00;
  localparam logic [7:0] CIJOP_OPC_IMM = 8'hBF;
  localparam logic [7:0] CIJOP_OPC_JMPF = 8'hB5;
  localparam logic [7:0] CIJOP_OPC_JMPI = 8'hB3;
  localparam int CIJOP_BR_DELAY = 3;
  localparam logic [31:0] CIJOP_PC_RST = 32'h0000_0000;
  localparam logic [31:0] CIJOP_ONE = 32'h0000_0001;
  localparam logic [31:0] CIJOP_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    CIJOP_SVC_NONE = 2'b00,
    CIJOP_SVC_EXC = 2'b01,
    CIJOP_SVC_INT = 2'b10
  } cijop_svc_t;
endpackage

// >>> core/cijop_unit.sv
// cijop_unit: executes signed greater-than compares, the signed constant load and
// the interruptible jumps; holds the jump-target, program and sequence counters
// assumes one operation per cycle on issue_valid, operands synchronous to ref_clk
//
// Functional notes
// RQ1 - register compare writes 1 when first source exceeds second, signed, latency one
// RQ2 - guarded register compare writes destination only when guard bit zero is 1
// RQ3 - immediate compare writes 1 when source exceeds signed 7-bit immediate
// RQ4 - guarded immediate compare writes destination only when guard bit zero is 1
// RQ5 - constant load copies the whole 32-bit immediate into the destination
// RQ6 - constant load ignores any guard and always writes its destination
// RQ7 - jump-on-false, condition 0, nothing pending: load all three counters after delay
// RQ8 - jump-on-false, condition 0, pending event: load jump-target only, start service
// RQ9 - jump-on-false with condition bit 1 takes no jump
// RQ10 - jump-on-false with false guard leaves all counters unchanged
// RQ11 - immediate jump, nothing pending: load all three counters with the address
// RQ12 - immediate jump, pending event: jump-target only, exception before interrupt
// RQ13 - immediate jump with false guard leaves all counters unchanged
// RQ14 - compare results are full words: one in bit zero, or all zeros
`timescale 1ns/1ps
module cijop_unit
  import cijop_pkg::*;
#(
  parameter int DELAY = CIJOP_BR_DELAY
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // issue
  input wire logic issue_valid,
  input wire logic [CIJOP_OPC_W-1:0] opcode,
  input wire logic guard_present,
  input wire logic [CIJOP_W-1:0] guard_value,
  input wire logic [CIJOP_W-1:0] first_source,
  input wire logic [CIJOP_W-1:0] second_source,
  input wire logic [CIJOP_W-1:0] modifier,
  input wire logic [5:0] dest_index_in,
  // pending events
  input wire logic exception_pending,
  input wire logic interrupt_pending,
  // result write-back
  output logic wb_valid,
  output logic [5:0] wb_index,
  output logic [CIJOP_W-1:0] wb_data,
  // control flow
  output logic [CIJOP_W-1:0] jump_target_counter,
  output logic [CIJOP_W-1:0] program_counter,
  output logic [CIJOP_W-1:0] sequence_counter,
  output logic service_start,
  output cijop_svc_t service_kind
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire guard_ok = !guard_present || guard_value[0];
  wire is_gtr = issue_valid && (opcode == CIJOP_OPC_GTR);
  wire is_gtri = issue_valid && (opcode == CIJOP_OPC_GTRI);
  wire is_imm = issue_valid && (opcode == CIJOP_OPC_IMM);
  wire is_jmpf = issue_valid && (opcode == CIJOP_OPC_JMPF);
  wire is_jmpi = issue_valid && (opcode == CIJOP_OPC_JMPI);

  // ------------------------------------------------------------
  // compares and constant load
  // ------------------------------------------------------------
  wire signed [CIJOP_W-1:0] imm_sext = {{(CIJOP_W-CIJOP_IMM7_W){modifier[CIJOP_IMM7_W-1]}},
                                        modifier[CIJOP_IMM7_W-1:0]};
  wire gtr_hit = $signed(first_source) > $signed(second_source);  // [RQ1]
  wire gtri_hit = $signed(first_source) > imm_sext;  // [RQ3]
  wire cmp_hit = is_gtr ? gtr_hit : gtri_hit;
  wire [CIJOP_W-1:0] cmp_word = cmp_hit ? CIJOP_ONE : CIJOP_ZERO;  // [RQ14]
  wire cmp_write = (is_gtr || is_gtri) && guard_ok;  // [RQ2] [RQ4]
  wire imm_write = is_imm;  // [RQ6]
  wire [CIJOP_W-1:0] wb_d = is_imm ? modifier : cmp_word;  // [RQ5]
  wire wb_fire = cmp_write || imm_write;

  // ------------------------------------------------------------
  // write-back registers
  // ------------------------------------------------------------
  // index and data hold their last value, so a refused compare leaves the port quiet
  logic wb_valid_q;
  logic [5:0] wb_index_q;
  logic [CIJOP_W-1:0] wb_data_q;

  wire wb_valid_d = wb_fire;
  wire [5:0] wb_index_d = wb_fire ? dest_index_in : wb_index_q;
  wire [CIJOP_W-1:0] wb_data_d = wb_fire ? wb_d : wb_data_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_valid_q <= 1'b0;
    end else begin
      wb_valid_q <= wb_valid_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_index_q <= 6'h00;
    end else begin
      wb_index_q <= wb_index_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_data_q <= CIJOP_ZERO;
    end else begin
      wb_data_q <= wb_data_d;
    end
  end

  // the register file sees the result one cycle after issue: latency one
  assign wb_valid = wb_valid_q;
  assign wb_index = wb_index_q;
  assign wb_data = wb_data_q;

  // ------------------------------------------------------------
  // jumps: target is caught at issue, pending state when the jump completes; counters load DELAY+1 cycles after issue
  // ------------------------------------------------------------
  // a jump issued while another is in flight is taken too; the scheduler avoids that
  wire jmpf_take = is_jmpf && guard_ok && !first_source[0];  // [RQ9] [RQ10]
  wire jmpi_take = is_jmpi && guard_ok;  // [RQ13]
  wire jump_take = jmpf_take || jmpi_take;
  wire [CIJOP_W-1:0] jump_addr = is_jmpi ? modifier : second_source;

  logic [DELAY-1:0] dly_v_q;
  logic [CIJOP_W-1:0] dly_a_q [DELAY];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dly_v_q <= '0;
    end else begin
      dly_v_q <= {dly_v_q[DELAY-2:0], jump_take};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DELAY; gi++) begin : g_dly
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          dly_a_q[gi] <= CIJOP_ZERO;
        end else if (gi == 0) begin
          dly_a_q[gi] <= jump_addr;
        end else begin
          dly_a_q[gi] <= dly_a_q[(gi == 0) ? 0 : gi-1];
        end
      end
    end
  endgenerate

  // pending events are sampled when the jump completes
  wire fire = dly_v_q[DELAY-1];
  wire [CIJOP_W-1:0] fire_addr = dly_a_q[DELAY-1];
  wire any_pending = exception_pending || interrupt_pending;
  wire cijop_svc_t svc_sel = exception_pending ? CIJOP_SVC_EXC :
                             (interrupt_pending ? CIJOP_SVC_INT : CIJOP_SVC_NONE);  // [RQ12]

  // the jump target is always recorded, so a service routine knows where to resume
  wire jtc_load = fire;  // [RQ8] [RQ12]
  // program and sequence counters only move when nothing asks for service
  wire pc_load = fire && !any_pending;  // [RQ7] [RQ11]

  // ------------------------------------------------------------
  // control-flow counters and service request
  // ------------------------------------------------------------
  logic [CIJOP_W-1:0] jtc_q;
  logic [CIJOP_W-1:0] pc_q;
  logic [CIJOP_W-1:0] sc_q;
  logic svc_start_q;
  cijop_svc_t svc_kind_q;

  wire [CIJOP_W-1:0] jtc_d = jtc_load ? fire_addr : jtc_q;
  wire [CIJOP_W-1:0] pc_d = pc_load ? fire_addr : pc_q;
  wire [CIJOP_W-1:0] sc_d = pc_load ? fire_addr : sc_q;
  wire svc_start_d = fire && any_pending;
  // kind is only meaningful with the start pulse; it returns to none otherwise
  wire cijop_svc_t svc_kind_d = fire ? svc_sel : CIJOP_SVC_NONE;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      jtc_q <= CIJOP_PC_RST;
    end else begin
      jtc_q <= jtc_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_q <= CIJOP_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sc_q <= CIJOP_PC_RST;
    end else begin
      sc_q <= sc_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      svc_start_q <= 1'b0;
    end else begin
      svc_start_q <= svc_start_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      svc_kind_q <= CIJOP_SVC_NONE;
    end else begin
      svc_kind_q <= svc_kind_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // all control-flow outputs come straight from flip-flops, so the fetch side sees no glitches
  assign jump_target_counter = jtc_q;
  assign program_counter = pc_q;
  assign sequence_counter = sc_q;
  assign service_start = svc_start_q;
  assign service_kind = svc_kind_q;

endmodule

// >>> dv/cijop_unit_properties.sv
// cijop_unit_properties: port-level timing checks of the compare/jump unit
// assumes pending levels are stable from issue to completion
`timescale 1ns/1ps
module cijop_unit_properties
  import cijop_pkg::*;
(
  // grouped per line to stay compact
  input wire logic ref_clk, nrst, issue_valid, guard_present, exception_pending, interrupt_pending,
  input wire logic [7:0] opcode,
  input wire logic [31:0] guard_value, first_source, second_source, modifier,
  input wire logic wb_valid, service_start,
  input wire logic [31:0] wb_data, jump_target_counter, program_counter,
  input cijop_svc_t service_kind
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire g = issue_valid && (!guard_present || guard_value[0]);
  a_gtr_result: assert property (g && opcode == CIJOP_OPC_GTR |=> wb_valid && wb_data ==
    ($signed($past(first_source)) > $signed($past(second_source)) ? CIJOP_ONE : CIJOP_ZERO)) else $error("gtr bad");
  a_cmp_refused: assert property (issue_valid && guard_present && !guard_value[0] &&
    (opcode == CIJOP_OPC_GTR || opcode == CIJOP_OPC_GTRI) |=> !wb_valid) else $error("false guard wrote");
  a_gtri_result: assert property (g && opcode == CIJOP_OPC_GTRI |=> wb_valid && wb_data ==
    ($signed($past(first_source)) > $signed($past(modifier[6:0])) ? CIJOP_ONE : CIJOP_ZERO)) else $error("gtri bad");
  a_const_load: assert property (issue_valid && opcode == CIJOP_OPC_IMM |=>
    wb_valid && wb_data == $past(modifier)) else $error("const load bad");
  a_jmpi_target: assert property (g && opcode == CIJOP_OPC_JMPI |->
    ##4 jump_target_counter == $past(modifier, 4)) else $error("jmpi target bad");
  a_jmpf_target: assert property (g && opcode == CIJOP_OPC_JMPF && !first_source[0] |->
    ##4 jump_target_counter == $past(second_source, 4)) else $error("jmpf target bad");
  a_jmpi_pc: assert property (g && opcode == CIJOP_OPC_JMPI ##3 !exception_pending && !interrupt_pending
    |=> program_counter == $past(modifier, 4)) else $error("jmpi pc bad");
  a_svc_kind: assert property (service_start |->
    service_kind == ($past(exception_pending) ? CIJOP_SVC_EXC : CIJOP_SVC_INT)) else $error("service kind bad");
endmodule
bind cijop_unit cijop_unit_properties cijop_unit_properties_inst (
  .ref_clk(ref_clk), .nrst(nrst), .issue_valid(issue_valid), .guard_present(guard_present),
  .exception_pending(exception_pending), .interrupt_pending(interrupt_pending), .opcode(opcode),
  .guard_value(guard_value), .first_source(first_source), .second_source(second_source), .modifier(modifier),
  .wb_valid(wb_valid), .service_start(service_start), .wb_data(wb_data),
  .jump_target_counter(jump_target_counter), .program_counter(program_counter), .service_kind(service_kind)
);

// >>> dv/testbench.sv
// testbench: directed checks of compares, constant load and jumps
// assumes inputs change at the falling edge, counters visible in cycle 4
`timescale 1ns/1ps
module testbench
  import cijop_pkg::*;
;
  logic ref_clk = 0, nrst = 0, issue_valid = 0, guard_present = 0, exception_pending = 0, interrupt_pending = 0;
  logic [7:0] opcode = 0;
  logic [31:0] guard_value = 0, first_source = 0, second_source = 0, modifier = 0;
  logic [5:0] dest_index_in = 0, wb_index;
  logic wb_valid, service_start;
  logic [31:0] wb_data, jump_target_counter, program_counter, sequence_counter;
  cijop_svc_t service_kind;
  int mismatches = 0, checks_done = 0;
  cijop_unit cijop_unit_inst (
    .ref_clk(ref_clk), .nrst(nrst), .issue_valid(issue_valid), .opcode(opcode),
    .guard_present(guard_present), .guard_value(guard_value), .first_source(first_source),
    .second_source(second_source), .modifier(modifier), .dest_index_in(dest_index_in),
    .exception_pending(exception_pending), .interrupt_pending(interrupt_pending),
    .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
    .jump_target_counter(jump_target_counter), .program_counter(program_counter),
    .sequence_counter(sequence_counter), .service_start(service_start), .service_kind(service_kind)
  );
  always #12.5 ref_clk = ~ref_clk;
  task iss(input logic [7:0] op, input logic gp, gv, input logic [31:0] a, b, m, input int w);
    @(negedge ref_clk);
    {issue_valid, opcode, guard_present, guard_value, first_source, second_source, modifier} = {1'b1, op, gp, 31'h0, gv, a, b, m};
    @(negedge ref_clk);
    issue_valid = 0;
    repeat (w) @(negedge ref_clk);
  endtask
  task chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task t_compare;
    dest_index_in = 6'h2A;
    iss(CIJOP_OPC_GTR, 0, 0, 32'h8000_0000, 32'h4, 0, 0); chk(wb_valid, 1); chk(wb_data, 0);
    chk(wb_index, 32'h2A);
    iss(CIJOP_OPC_GTR, 1, 1, 32'h1000, 32'h100, 0, 0); chk(wb_data, 32'h1);
    iss(CIJOP_OPC_GTR, 1, 0, 32'h100, 32'h3, 0, 0); chk(wb_valid, 0); chk(wb_data, 1);
    iss(CIJOP_OPC_GTRI, 0, 0, 32'h3, 0, 32'h3, 0); chk(wb_data, 0);
    iss(CIJOP_OPC_GTRI, 0, 0, 32'h3, 0, 32'h40, 0); chk(wb_data, 1);
    iss(CIJOP_OPC_GTRI, 1, 0, 0, 0, 0, 0); chk(wb_valid, 0);
    iss(CIJOP_OPC_IMM, 1, 0, 0, 0, 32'hFFFC_0000, 0); chk(wb_data, 32'hFFFC_0000);
    $display("compare test done");
  endtask
  task t_jump;
    iss(CIJOP_OPC_JMPI, 0, 0, 0, 0, 32'h330, 3); chk(sequence_counter, 32'h330);
    chk(program_counter, 32'h330); chk(jump_target_counter, 32'h330);
    iss(CIJOP_OPC_JMPF, 0, 0, 1, 32'h8000, 0, 3); chk(jump_target_counter, 32'h330);
    iss(CIJOP_OPC_JMPF, 1, 0, 0, 32'h8000, 0, 3); chk(program_counter, 32'h330);
    iss(CIJOP_OPC_JMPI, 1, 0, 0, 0, 32'h44, 3); chk(jump_target_counter, 32'h330);
    {exception_pending, interrupt_pending} = 2'b11;
    iss(CIJOP_OPC_JMPF, 1, 1, 0, 32'h8000, 0, 3); chk(service_start, 1); chk(service_kind, CIJOP_SVC_EXC);
    chk(jump_target_counter, 32'h8000); chk(program_counter, 32'h330);
    exception_pending = 0;
    iss(CIJOP_OPC_JMPI, 1, 1, 0, 0, 32'h44, 3); chk(service_kind, CIJOP_SVC_INT); chk(program_counter, 32'h330);
    chk(jump_target_counter, 32'h44); chk(sequence_counter, 32'h330);
    interrupt_pending = 0;
    iss(CIJOP_OPC_JMPF, 0, 0, 0, 32'h8000, 0, 3); chk(program_counter, 32'h8000);
    chk(sequence_counter, 32'h8000); chk(service_start, 0);
    $display("jump test done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    nrst = 1;
    t_compare;
    t_jump;
    stop_test;
  end
  initial begin
    #5000;
    mismatches++;
    stop_test;
  end
endmodule
